//--- hw/dps_core.sv
// Functional notes
// - After reset the drive sits in not-ready-to-switch-on with the output shut off.
// - When initialization ends the drive moves alone to switch-on-disabled.
// - Enable operation is refused while the drive-ready output is off.
// - Disable operation leaves operation-enabled only once stopped and not braking or pre-exciting.
// - Operation-enabled is also left when the drive-ready output drops.
// - Disable voltage or quick stop from ready or switched-on goes to switch-on-disabled.
// - Quick stop enters quick-stop-active unless unused with a stop input assigned.
// - Under position control quick-stop-active ends when busy drops or on disable voltage.
// - Otherwise quick-stop-active ends once stopped and not braking or pre-exciting.
// - Quick-stop-active also ends when an emergency stop completes.
// - A fault reset clears the protection and moves fault to switch-on-disabled.
// - Severe fault codes are not cleared by a fault reset.
// - Cancelling transitions drop servo-on or run-start.
// - Any failed enabling condition forces switch-on-disabled.
`timescale 1ns/1ps
module dps_core
   import dps_pkg::*;
#(
   parameter int INIT_COUNT = INIT_CYCLES
)(
   input  wire logic              clock,
   input  wire logic              rst,
   input  wire logic [CW_W-1:0]   pdo_cw,
   input  wire logic              pdo_cw_valid,
   input  wire logic [CW_W-1:0]   sdo_cw,
   input  wire logic              sdo_cw_valid,
   input  wire logic              init_done_in,
   input  wire logic              output_permit,
   input  wire logic              motor_stopped,
   input  wire logic              dc_brake_active,
   input  wire logic              pre_excite_active,
   input  wire logic              positioning_busy,
   input  wire logic              estop_complete,
   input  wire logic              fault_detect,
   input  wire logic [FAULT_W-1:0] fault_code_in,
   input  wire logic [ADDR_W-1:0] reg_addr,
   input  wire logic [DATA_W-1:0] reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic [DATA_W-1:0]      reg_rdata,
   output logic [3:0]             state_out,
   output logic                   drive_ready_output,
   output logic                   servo_on_input,
   output logic                   run_start,
   output logic                   quick_stop_req,
   output logic                   protect_reset,
   output logic                   irq
);

   // Elaboration stops when the start-up count does not fit its counter.
   if (INIT_COUNT < 1 || INIT_COUNT >= (1 << INIT_CNT_W)) begin : g_bad_init
      $error("INIT_COUNT out of range");
   end

   dps_cmd_if cif ();

   // Service-data words are deliberately not connected to the decoder.
   assign cif.cw       = pdo_cw;
   assign cif.cw_valid = pdo_cw_valid;

   dps_cmd_decode u_dec (
      .clock (clock),
      .rst   (rst),
      .cif   (cif)
   );

   function automatic logic is_severe(input logic [FAULT_W-1:0] code);
      logic hit;
      hit = 1'b0;
      for (int i = 0; i < N_SEVERE; i++) begin
         if (code == SEVERE_CODES[i]) begin
            hit = 1'b1;
         end
      end
      return hit;
   endfunction

   dps_state_e            st_r, st_nxt;
   logic [INIT_CNT_W-1:0] init_cnt_r, init_cnt_nxt;
   logic [CTRL_W-1:0]     ctrl_r, ctrl_nxt;
   logic [IRQ_W-1:0]      irq_st_r, irq_st_nxt;
   logic [IRQ_W-1:0]      irq_mk_r, irq_mk_nxt;
   logic [FAULT_W-1:0]    fault_r, fault_nxt;
   logic                  ready_r, ready_nxt;
   logic                  servo_r, servo_nxt;
   logic                  run_r, run_nxt;
   logic                  qs_r, qs_nxt;
   logic                  prst_r, prst_nxt;
   logic [DATA_W-1:0]     rdata_r, rdata_nxt;
   logic                  enabled;
   logic                  stopped_ok;
   logic                  rejected;
   logic [IRQ_W-1:0]      ev;
   logic                  qs_blocked;
   logic                  irq_r, irq_nxt;

   assign enabled = ctrl_r[CTRL_NETMODE] && ctrl_r[CTRL_PORTSEL] && ctrl_r[CTRL_SRC0];
   assign stopped_ok = motor_stopped && !dc_brake_active && !pre_excite_active;
   // A blocked quick stop falls through, so a drive-ready drop still leaves operation.
   assign qs_blocked = ctrl_r[CTRL_QSUNUSE] && ctrl_r[CTRL_STOPASG];

   always_comb begin
      st_nxt       = st_r;
      init_cnt_nxt = init_cnt_r;
      fault_nxt    = fault_r;
      prst_nxt     = 1'b0;
      rejected     = 1'b0;
      if (init_cnt_r != '0) begin
         init_cnt_nxt = init_cnt_r - 1'b1;
      end
      if (fault_detect && st_r != ST_FAULT && st_r != ST_FAULT_REAC) begin
         st_nxt    = ST_FAULT_REAC;
         fault_nxt = fault_code_in;
      end else begin
         unique case (st_r)
            ST_NOT_READY: begin
               if (init_cnt_r == '0 && init_done_in) begin
                  st_nxt = ST_SW_DIS;
               end
            end
            ST_SW_DIS: begin
               if (enabled && cif.cmd == CMD_SHUTDOWN) begin
                  st_nxt = ST_READY;
               end else if (enabled && cif.cmd == CMD_SWITCHON) begin
                  st_nxt = ST_SWITCHED;
               end else if (enabled && cif.cmd == CMD_ENOP) begin
                  if (ready_r) begin
                     st_nxt = ST_OP_EN;
                  end else begin
                     rejected = 1'b1;
                  end
               end
            end
            ST_READY: begin
               if (!enabled || cif.cmd == CMD_DISVOLT || cif.cmd == CMD_QSTOP) begin
                  st_nxt = ST_SW_DIS;
               end else if (cif.cmd == CMD_SWITCHON) begin
                  st_nxt = ST_SWITCHED;
               end else if (cif.cmd == CMD_ENOP) begin
                  if (ready_r) begin
                     st_nxt = ST_OP_EN;
                  end else begin
                     rejected = 1'b1;
                  end
               end
            end
            ST_SWITCHED: begin
               if (!enabled || cif.cmd == CMD_DISVOLT || cif.cmd == CMD_QSTOP) begin
                  st_nxt = ST_SW_DIS;
               end else if (cif.cmd == CMD_SHUTDOWN) begin
                  st_nxt = ST_READY;
               end else if (cif.cmd == CMD_ENOP) begin
                  if (ready_r) begin
                     st_nxt = ST_OP_EN;
                  end else begin
                     rejected = 1'b1;
                  end
               end
            end
            ST_OP_EN: begin
               if (!enabled || cif.cmd == CMD_DISVOLT) begin
                  st_nxt = ST_SW_DIS;
               end else if (cif.cmd == CMD_QSTOP && !qs_blocked) begin
                  st_nxt = ST_QSTOP;
               end else if (cif.cmd == CMD_SHUTDOWN) begin
                  st_nxt = ST_READY;
               end else if (!ready_r) begin
                  st_nxt = ST_SWITCHED;
               end else if (cif.cmd == CMD_SWITCHON && stopped_ok) begin
                  st_nxt = ST_SWITCHED;
               end
            end
            ST_QSTOP: begin
               if (!enabled || cif.cmd == CMD_DISVOLT || estop_complete) begin
                  st_nxt = ST_SW_DIS;
               end else if (ctrl_r[CTRL_POSCTL] && !positioning_busy) begin
                  st_nxt = ST_SW_DIS;
               end else if (!ctrl_r[CTRL_POSCTL] && stopped_ok) begin
                  st_nxt = ST_SW_DIS;
               end
            end
            ST_FAULT_REAC: begin
               st_nxt = ST_FAULT;
            end
            ST_FAULT: begin
               if (cif.fault_reset && !is_severe(fault_r)) begin
                  st_nxt    = ST_SW_DIS;
                  fault_nxt = '0;
                  prst_nxt  = 1'b1;
               end
            end
            default: begin
               st_nxt = ST_NOT_READY;
            end
         endcase
      end
   end

   // Output and run control follow the next state so they change with it.
   always_comb begin
      ready_nxt = (st_nxt == ST_SWITCHED || st_nxt == ST_OP_EN || st_nxt == ST_QSTOP)
                  && output_permit;
      qs_nxt    = (st_nxt == ST_QSTOP);
      servo_nxt = (st_nxt == ST_OP_EN) && ctrl_r[CTRL_POSCTL];
      run_nxt   = (st_nxt == ST_OP_EN) && !ctrl_r[CTRL_POSCTL];
   end

   // A status bit set by an event in the same cycle as its clear stays set.
   always_comb begin
      ev             = '0;
      ev[IRQ_STATE]  = (st_nxt != st_r);
      ev[IRQ_FAULT]  = (st_nxt == ST_FAULT_REAC) && (st_r != ST_FAULT_REAC);
      ev[IRQ_REJECT] = rejected;
   end

   always_comb begin
      ctrl_nxt   = ctrl_r;
      irq_mk_nxt = irq_mk_r;
      irq_st_nxt = irq_st_r;
      rdata_nxt  = '0;
      if (reg_wr) begin
         unique case (reg_addr)
            REG_CTRL:   ctrl_nxt   = reg_wdata[CTRL_W-1:0];
            REG_IRQ_ST: irq_st_nxt = irq_st_r & ~reg_wdata[IRQ_W-1:0];
            REG_IRQ_MK: irq_mk_nxt = reg_wdata[IRQ_W-1:0];
            default: begin
            end
         endcase
      end
      irq_st_nxt = irq_st_nxt | ev;
      irq_nxt    = |(irq_st_nxt & irq_mk_nxt);
      if (reg_rd) begin
         unique case (reg_addr)
            REG_CTRL:   rdata_nxt = {{(DATA_W-CTRL_W){1'b0}}, ctrl_r};
            REG_STATE:  rdata_nxt = {{(DATA_W-4){1'b0}}, st_r};
            REG_IRQ_ST: rdata_nxt = {{(DATA_W-IRQ_W){1'b0}}, irq_st_r};
            REG_IRQ_MK: rdata_nxt = {{(DATA_W-IRQ_W){1'b0}}, irq_mk_r};
            REG_FAULT:  rdata_nxt = {{(DATA_W-FAULT_W){1'b0}}, fault_r};
            default:    rdata_nxt = '0;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         st_r       <= ST_NOT_READY;
         init_cnt_r <= INIT_CNT_W'(INIT_COUNT);
         fault_r    <= '0;
         prst_r     <= 1'b0;
      end else begin
         st_r       <= st_nxt;
         init_cnt_r <= init_cnt_nxt;
         fault_r    <= fault_nxt;
         prst_r     <= prst_nxt;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         ready_r    <= 1'b0;
         servo_r    <= 1'b0;
         run_r      <= 1'b0;
         qs_r       <= 1'b0;
      end else begin
         ready_r    <= ready_nxt;
         servo_r    <= servo_nxt;
         run_r      <= run_nxt;
         qs_r       <= qs_nxt;
      end
   end

   // Register port, sticky status and the level interrupt.
   always_ff @(posedge clock) begin
      if (rst) begin
         ctrl_r     <= CTRL_RST;
         irq_st_r   <= '0;
         irq_mk_r   <= IRQ_MASK_RST;
         rdata_r    <= '0;
         irq_r      <= 1'b0;
      end else begin
         ctrl_r     <= ctrl_nxt;
         irq_st_r   <= irq_st_nxt;
         irq_mk_r   <= irq_mk_nxt;
         rdata_r    <= rdata_nxt;
         irq_r      <= irq_nxt;
      end
   end

   assign reg_rdata          = rdata_r;
   assign state_out          = st_r;
   assign drive_ready_output = ready_r;
   assign servo_on_input     = servo_r;
   assign run_start          = run_r;
   assign quick_stop_req     = qs_r;
   assign protect_reset      = prst_r;
   assign irq                = irq_r;

endmodule

//--- hw/dps_pkg.sv
package dps_pkg;

   // Width of a fault code and of the process-data control word.
   localparam int FAULT_W = 8;
   localparam int CW_W    = 16;

   // Control word bit positions.
   localparam int CW_SO = 0;
   localparam int CW_EV = 1;
   localparam int CW_QS = 2;
   localparam int CW_EO = 3;
   localparam int CW_FR = 7;

   // Register bus width and offsets.
   localparam int ADDR_W = 4;
   localparam int DATA_W = 16;
   localparam logic [ADDR_W-1:0] REG_CTRL   = 4'h0;
   localparam logic [ADDR_W-1:0] REG_STATE  = 4'h1;
   localparam logic [ADDR_W-1:0] REG_IRQ_ST = 4'h2;
   localparam logic [ADDR_W-1:0] REG_IRQ_MK = 4'h3;
   localparam logic [ADDR_W-1:0] REG_FAULT  = 4'h4;

   // Control register fields.
   localparam int CTRL_NETMODE = 0;
   localparam int CTRL_PORTSEL = 1;
   localparam int CTRL_SRC0    = 2;
   localparam int CTRL_POSCTL  = 3;
   localparam int CTRL_QSUNUSE = 4;
   localparam int CTRL_STOPASG = 5;
   localparam int CTRL_W       = 6;
   localparam logic [CTRL_W-1:0] CTRL_RST = 6'h00;

   // Interrupt status bit positions.
   localparam int IRQ_STATE  = 0;
   localparam int IRQ_FAULT  = 1;
   localparam int IRQ_REJECT = 2;
   localparam int IRQ_W      = 3;
   localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;

   // Severe fault codes that survive a fault reset (arbitrary encodings).
   localparam int N_SEVERE = 4;
   localparam logic [FAULT_W-1:0] SEVERE_CODES [N_SEVERE] = '{8'h10, 8'h11, 8'h20, 8'h21};

   // Initialization time after reset.
   localparam int CLK_HZ      = 25_000_000;
   localparam int INIT_US     = 100;
   localparam int INIT_CYCLES = (CLK_HZ / 1_000_000) * INIT_US;
   localparam int INIT_CNT_W  = 12;

   typedef enum logic [3:0] {
      ST_NOT_READY  = 4'h0,
      ST_SW_DIS     = 4'h1,
      ST_READY      = 4'h2,
      ST_SWITCHED   = 4'h3,
      ST_OP_EN      = 4'h4,
      ST_QSTOP      = 4'h5,
      ST_FAULT_REAC = 4'h6,
      ST_FAULT      = 4'h7
   } dps_state_e;

   typedef enum logic [2:0] {
      CMD_NONE     = 3'h0,
      CMD_SHUTDOWN = 3'h1,
      CMD_SWITCHON = 3'h2,
      CMD_DISVOLT  = 3'h3,
      CMD_QSTOP    = 3'h4,
      CMD_DISOP    = 3'h5,
      CMD_ENOP     = 3'h6
   } dps_cmd_e;

endpackage

//--- hw/dps_cmd_if.sv
`timescale 1ns/1ps
interface dps_cmd_if;
   import dps_pkg::*;
   logic [CW_W-1:0] cw;
   logic            cw_valid;
   dps_cmd_e        cmd;
   logic            fault_reset;

   modport decoder (input cw, input cw_valid, output cmd, output fault_reset);
   modport core    (output cw, output cw_valid, input cmd, input fault_reset);
endinterface

//--- hw/dps_cmd_decode.sv
`timescale 1ns/1ps
module dps_cmd_decode
   import dps_pkg::*;
(
   input  wire logic   clock,
   input  wire logic   rst,
   dps_cmd_if.decoder  cif
);

   logic fr_prev_r;
   logic fr_prev_nxt;

   always_comb begin
      fr_prev_nxt = cif.cw_valid ? cif.cw[CW_FR] : fr_prev_r;
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         fr_prev_r <= 1'b0;
      end else begin
         fr_prev_r <= fr_prev_nxt;
      end
   end

   // Fault reset acts on the 0 to 1 edge of its bit.
   assign cif.fault_reset = cif.cw_valid && cif.cw[CW_FR] && !fr_prev_r;

   always_comb begin
      cif.cmd = CMD_NONE;
      if (cif.cw_valid && !cif.cw[CW_FR]) begin
         if (!cif.cw[CW_EV]) begin
            cif.cmd = CMD_DISVOLT;
         end else if (!cif.cw[CW_QS]) begin
            cif.cmd = CMD_QSTOP;
         end else if (!cif.cw[CW_SO]) begin
            cif.cmd = CMD_SHUTDOWN;
         end else if (cif.cw[CW_EO]) begin
            cif.cmd = CMD_ENOP;
         end else begin
            cif.cmd = CMD_SWITCHON;
         end
      end
   end

endmodule

//--- dv/dps_master_model.sv
`timescale 1ns/1ps
module dps_master_model
   import dps_pkg::*;
(
   input  wire logic            clock,
   output logic [CW_W-1:0]      cw,
   output logic                 cw_valid
);
   initial begin
      cw = '0;
      cw_valid = 1'b0;
   end
   // One cyclic word per call; between words the line shows a changed value.
   task automatic send(input logic [CW_W-1:0] w);
      @(posedge clock);
      cw <= w;
      cw_valid <= 1'b1;
      @(posedge clock);
      cw <= ~w;
      cw_valid <= 1'b0;
   endtask
   // The reset bit steps from 0 to 1 across two valid words.
   task automatic fault_reset();
      send(16'h0000);
      send(16'h0080);
   endtask
endmodule

//--- dv/dps_core_chk.sv
`timescale 1ns/1ps
module dps_core_chk
   import dps_pkg::*;
(
   input wire logic            clock,
   input wire logic            rst,
   input wire logic [CW_W-1:0] pdo_cw,
   input wire logic            pdo_cw_valid,
   input wire logic            output_permit,
   input wire logic            motor_stopped,
   input wire logic            fault_detect,
   input wire logic            reg_wr,
   input wire logic [3:0]      state_out,
   input wire logic            drive_ready_output,
   input wire logic            servo_on_input,
   input wire logic            run_start,
   input wire logic            quick_stop_req,
   input wire logic            protect_reset
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   sequence fault_seq;
      state_out == 4'h6 ##1 state_out == 4'h7;
   endsequence
   init_state_a: assert property (
      $fell(rst) |-> state_out == 4'h0 && !drive_ready_output) else $error("bad reset state");
   enop_refuse_a: assert property (
      pdo_cw_valid && pdo_cw[7:0] == 8'h0F && state_out != 4'h4 && !drive_ready_output
      && !fault_detect && !reg_wr |=> state_out != 4'h4) else $error("enable not refused");
   disop_hold_a: assert property (
      state_out == 4'h4 && drive_ready_output && output_permit && !motor_stopped
      && pdo_cw_valid && pdo_cw[7:0] == 8'h07 && !fault_detect && !reg_wr
      |=> state_out == 4'h4) else $error("left before stop");
   ready_drop_a: assert property (
      state_out == 4'h4 && !output_permit |-> ##[1:2] state_out != 4'h4)
      else $error("stayed enabled without ready");
   fault_path_a: assert property (
      fault_detect && state_out inside {[4'h1:4'h5]} |=> fault_seq) else $error("bad fault path");
   output_dark_a: assert property (
      state_out inside {4'h0, 4'h1, 4'h2, 4'h6, 4'h7} |-> !drive_ready_output)
      else $error("ready in shut state");
   run_cancel_a: assert property (
      state_out != 4'h4 |-> !run_start && !servo_on_input) else $error("run kept");
   qstop_flag_a: assert property (
      quick_stop_req == (state_out == 4'h5)) else $error("quick stop flag wrong");
   reset_pulse_a: assert property (
      protect_reset |=> !protect_reset) else $error("reset pulse too long");
   idle_hold_a: assert property (
      state_out inside {4'h2, 4'h3} && output_permit && !pdo_cw_valid && !fault_detect
      && !reg_wr && !$past(reg_wr) |=> $stable(state_out)) else $error("moved without word");
endmodule

bind dps_core dps_core_chk chk (
   .clock(clock), .rst(rst), .pdo_cw(pdo_cw), .pdo_cw_valid(pdo_cw_valid),
   .output_permit(output_permit), .motor_stopped(motor_stopped),
   .fault_detect(fault_detect), .reg_wr(reg_wr), .state_out(state_out),
   .drive_ready_output(drive_ready_output), .servo_on_input(servo_on_input),
   .run_start(run_start), .quick_stop_req(quick_stop_req), .protect_reset(protect_reset)
);

//--- dv/drive_power_state_machine_tb.sv
`timescale 1ns/1ps
module drive_power_state_machine_tb;
   import dps_pkg::*;
   logic               clock, rst, pdo_cw_valid, sdo_cw_valid, init_done_in, output_permit;
   logic               motor_stopped, dc_brake_active, pre_excite_active, positioning_busy;
   logic               estop_complete, fault_detect, reg_wr, reg_rd, drive_ready_output;
   logic               servo_on_input, run_start, quick_stop_req, protect_reset, irq;
   logic [CW_W-1:0]    pdo_cw, sdo_cw;
   logic [FAULT_W-1:0] fault_code_in;
   logic [3:0]         reg_addr, state_out;
   logic [15:0]        reg_wdata, reg_rdata;
   int                 num_errors, checks_done;

   dps_core #(.INIT_COUNT(4)) dut (
      .clock(clock), .rst(rst), .pdo_cw(pdo_cw), .pdo_cw_valid(pdo_cw_valid),
      .sdo_cw(sdo_cw), .sdo_cw_valid(sdo_cw_valid), .init_done_in(init_done_in),
      .output_permit(output_permit), .motor_stopped(motor_stopped),
      .dc_brake_active(dc_brake_active), .pre_excite_active(pre_excite_active),
      .positioning_busy(positioning_busy), .estop_complete(estop_complete),
      .fault_detect(fault_detect), .fault_code_in(fault_code_in), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .state_out(state_out), .drive_ready_output(drive_ready_output),
      .servo_on_input(servo_on_input), .run_start(run_start),
      .quick_stop_req(quick_stop_req), .protect_reset(protect_reset), .irq(irq)
   );
   dps_master_model m (.clock(clock), .cw(pdo_cw), .cw_valid(pdo_cw_valid));

   task automatic wrap_up();
      $display("errors %0d checks %0d", num_errors, checks_done);
      if (num_errors == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic fail(input string s);
      num_errors++;
      $display("[FAIL] %0t %s", $time, s);
   endtask
   task automatic check(input logic [15:0] g, input logic [15:0] e, input string s);
      checks_done++;
      if (g !== e) fail(s);
   endtask
   task automatic wait_st(input logic [3:0] s);
      int n;
      n = 0;
      while (state_out !== s && n < 40) begin
         @(posedge clock);
         #1;
         n++;
      end
      checks_done++;
      if (n == 40) begin
         fail("state not reached");
         wrap_up();
      end
   endtask
   task automatic go(input logic [15:0] w, input logic [3:0] s);
      m.send(w);
      wait_st(s);
   endtask
   task automatic stay(input logic [15:0] w, input logic [3:0] s);
      m.send(w);
      repeat (3) @(posedge clock);
      #1;
      check(state_out, s, "state moved");
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask
   task automatic rdc(input logic [3:0] a, input logic [15:0] e, input logic [15:0] mk);
      @(posedge clock);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1;
      check(reg_rdata & mk, e, "read data");
   endtask
   task automatic up();
      go(16'h0006, 4'h2);
      go(16'h0007, 4'h3);
      go(16'h000F, 4'h4);
   endtask
   task automatic hit(input logic [7:0] c);
      fault_code_in <= c;
      fault_detect <= 1'b1;
      @(posedge clock);
      fault_detect <= 1'b0;
      wait_st(4'h7);
   endtask

   task automatic t_init();
      check(state_out, 4'h0, "not in init");
      check(drive_ready_output, 1'h0, "output on");
      rdc(REG_CTRL, 16'h0000, 16'hFFFF);
      rdc(REG_IRQ_MK, 16'h0000, 16'hFFFF);
      rdc(4'hF, 16'h0000, 16'hFFFF);
      check(state_out, 4'h0, "left init early");
      init_done_in <= 1'b1;
      wait_st(4'h1);
   endtask
   task automatic t_src();
      stay(16'h0006, 4'h1);
      wr(REG_CTRL, 16'h0007);
      wr(4'hF, 16'hFFFF);
      rdc(REG_CTRL, 16'h0007, 16'hFFFF);
      go(16'h0006, 4'h2);
      wr(REG_CTRL, 16'h0003);
      wait_st(4'h1);
      wr(REG_CTRL, 16'h0007);
   endtask
   task automatic t_walk();
      motor_stopped <= 1'b0;
      up();
      check(run_start, 1'h1, "no run start");
      check(drive_ready_output, 1'h1, "output off");
      check(servo_on_input, 1'h0, "servo on");
      rdc(REG_STATE, 16'h0004, 16'hFFFF);
      @(posedge clock);
      sdo_cw_valid <= 1'b1;
      @(posedge clock);
      sdo_cw_valid <= 1'b0;
      repeat (3) @(posedge clock);
      #1;
      check(state_out, 4'h4, "service word used");
   endtask
   task automatic t_disop();
      stay(16'h0007, 4'h4);
      motor_stopped <= 1'b1;
      dc_brake_active <= 1'b1;
      stay(16'h0007, 4'h4);
      dc_brake_active <= 1'b0;
      pre_excite_active <= 1'b1;
      stay(16'h0007, 4'h4);
      pre_excite_active <= 1'b0;
      go(16'h0007, 4'h3);
      check(run_start, 1'h0, "run kept");
   endtask
   task automatic t_refuse();
      output_permit <= 1'b0;
      wr(REG_IRQ_ST, 16'h0007);
      wr(REG_IRQ_MK, 16'h0004);
      #1;
      check(irq, 1'h0, "masked irq");
      stay(16'h000F, 4'h3);
      rdc(REG_IRQ_ST, 16'h0004, 16'h0004);
      check(irq, 1'h1, "no irq");
      wr(REG_IRQ_ST, 16'h0004);
      repeat (2) @(posedge clock);
      #1;
      check(irq, 1'h0, "irq not cleared");
      output_permit <= 1'b1;
      wr(REG_IRQ_MK, 16'h0000);
      go(16'h000F, 4'h4);
      output_permit <= 1'b0;
      wait_st(4'h3);
      check(run_start, 1'h0, "run kept");
      output_permit <= 1'b1;
   endtask
   task automatic t_qstop();
      motor_stopped <= 1'b0;
      go(16'h000F, 4'h4);
      go(16'h0002, 4'h5);
      check(quick_stop_req, 1'h1, "no quick stop request");
      motor_stopped <= 1'b1;
      wait_st(4'h1);
      up();
      motor_stopped <= 1'b0;
      go(16'h0002, 4'h5);
      estop_complete <= 1'b1;
      wait_st(4'h1);
      estop_complete <= 1'b0;
      wr(REG_CTRL, 16'h000F);
      up();
      check(servo_on_input, 1'h1, "no servo on");
      positioning_busy <= 1'b1;
      go(16'h0002, 4'h5);
      positioning_busy <= 1'b0;
      wait_st(4'h1);
      up();
      positioning_busy <= 1'b1;
      go(16'h0002, 4'h5);
      go(16'h0000, 4'h1);
      positioning_busy <= 1'b0;
      wr(REG_CTRL, 16'h0037);
      up();
      m.send(16'h0002);
      repeat (3) @(posedge clock);
      #1;
      check(state_out, 4'h4, "quick stop not blocked");
      wr(REG_CTRL, 16'h0007);
   endtask
   task automatic t_fault();
      hit(8'h05);
      check(drive_ready_output, 1'h0, "output on in fault");
      rdc(REG_FAULT, 16'h0005, 16'h00FF);
      m.fault_reset();
      #1;
      check(protect_reset, 1'h1, "no protection reset");
      wait_st(4'h1);
      go(16'h0006, 4'h2);
      go(16'h0002, 4'h1);
      go(16'h0006, 4'h2);
      go(16'h0007, 4'h3);
      go(16'h0000, 4'h1);
      hit(8'h10);
      m.fault_reset();
      repeat (4) @(posedge clock);
      #1;
      check(state_out, 4'h7, "severe fault cleared");
      rst <= 1'b1;
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      #1;
      check(state_out, 4'h0, "not in init");
      wait_st(4'h1);
   endtask

   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   initial begin
      num_errors = 0;
      checks_done = 0;
      {sdo_cw_valid, init_done_in, motor_stopped, dc_brake_active, pre_excite_active} = '0;
      {positioning_busy, estop_complete, fault_detect, reg_wr, reg_rd} = '0;
      {sdo_cw, fault_code_in, reg_addr, reg_wdata} = '0;
      output_permit = 1'b1;
      rst = 1'b1;
      repeat (10) @(posedge clock);
      rst <= 1'b0;
      t_init();
      t_src();
      t_walk();
      t_disop();
      t_refuse();
      t_qstop();
      t_fault();
      wrap_up();
   end
endmodule
